// [src/tdb_cell.sv]
/*
  One detector cell: double biquad filter, power estimator and static level,
  with its coefficient store. The comparator and the routing live in the top.
  Assumes strobes and inputs from logic on the same clock.
*/
`default_nettype none
module tdb_cell
  import tdb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // sequencing
  input wire logic init_state,
  input wire logic init_coef,
  input wire logic samp_stb,
  // routed inputs
  input wire logic signed [15:0] filt_in,
  input wire logic signed [15:0] pow_in,
  // coefficient access
  input wire logic wr_en,
  input wire logic zero_en,
  input wire logic [3:0] wr_idx,
  input wire logic [15:0] wr_data,
  input wire logic [3:0] rd_idx,
  output logic [15:0] rd_data,
  // results
  output logic signed [15:0] filt_out,
  output logic signed [15:0] pow_out,
  output logic signed [15:0] level_out
);
  logic signed [15:0] coef_r [TDB_NUM_COEF];
  logic signed [15:0] s1w1_r, s1w2_r, s2w1_r, s2w2_r, filt_r;
  logic signed [15:0] abs_r, pow_r;
  logic signed [15:0] w1, y1, w2, y2, abs_nxt, pow_nxt;
  logic signed [16:0] pdiff;
  logic signed [35:0] pstep;

  // gain*a + 2*c1*b + 2*c2*c, rescaled from Q30 to Q15
  function automatic logic signed [35:0] mac3(input logic signed [15:0] g,
      input logic signed [15:0] a, input logic signed [15:0] c1, input logic signed [15:0] b,
      input logic signed [15:0] c2, input logic signed [15:0] c);
    logic signed [35:0] acc;
    acc = 36'(g * a) + 36'(c1 * b) * 2 + 36'(c2 * c) * 2;
    return acc >>> 15;
  endfunction

  // two second-order sections, each saturating rather than wrapping
  assign w1 = tdb_sat16(mac3(coef_r[0], filt_in, coef_r[1], s1w1_r, coef_r[2], s1w2_r));
  assign y1 = tdb_sat16(mac3(coef_r[5], w1, coef_r[3], s1w1_r, coef_r[4], s1w2_r));
  assign w2 = tdb_sat16(mac3(coef_r[6], y1, coef_r[7], s2w1_r, coef_r[8], s2w2_r));
  assign y2 = tdb_sat16(mac3(coef_r[11], w2, coef_r[9], s2w1_r, coef_r[10], s2w2_r));

  // leaky integrator: out += P1*(|x delayed| - out), same as (1-P1)*out + P1*|x|
  assign abs_nxt = (pow_in == TDB_SAT_LO) ? TDB_SAT_HI : (pow_in < 0 ? -pow_in : pow_in);
  assign pdiff = 17'(abs_r) - 17'(pow_r);
  assign pstep = 36'(coef_r[TDB_IDX_SMOOTH] * pdiff) >>> 15;
  assign pow_nxt = tdb_sat16(36'(pow_r) + pstep);

  assign rd_data = (rd_idx < 4'(TDB_NUM_COEF)) ? coef_r[rd_idx] : 16'h0000;
  assign filt_out = filt_r;
  assign pow_out = pow_r;
  assign level_out = coef_r[TDB_IDX_LEVEL];

  // coefficient store, Q15 words; a kept store survives tone-mode entry
  always_ff @(posedge clk) begin
    for (int k = 0; k < TDB_NUM_COEF; k++) begin
      if (sys_rst || init_coef || zero_en) coef_r[k] <= 16'sh0000;
      else if (wr_en && wr_idx == 4'(k)) coef_r[k] <= wr_data;
    end
  end

  // per-sample state; filt_r is the trailing one-sample delay
  always_ff @(posedge clk) begin
    if (sys_rst || init_state || zero_en) begin
      s1w1_r <= 16'sh0000;
      s1w2_r <= 16'sh0000;
      s2w1_r <= 16'sh0000;
      s2w2_r <= 16'sh0000;
      filt_r <= 16'sh0000;
      abs_r <= 16'sh0000;
      pow_r <= 16'sh0000;
    end else if (samp_stb) begin
      s1w1_r <= w1;
      s1w2_r <= s1w1_r;
      s2w1_r <= w2;
      s2w2_r <= s2w1_r;
      filt_r <= y2;
      abs_r <= abs_nxt;
      pow_r <= pow_nxt;
    end
  end

  idle_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !samp_stb && !init_state && !zero_en |=> $stable(filt_r) && $stable(pow_r))
    else $error("cell state moved without a sample strobe");
  quiet_power_a: assert property (@(posedge clk) disable iff (sys_rst)
    samp_stb && !init_state && !zero_en && pow_r == 16'sh0000 && abs_r == 16'sh0000
    |=> pow_r == 16'sh0000)
    else $error("power estimate rose from silence");
  zero_cell_a: assert property (@(posedge clk) disable iff (sys_rst)
    zero_en |=> level_out == 16'sh0000 && filt_r == 16'sh0000)
    else $error("zeroed cell kept a value");
endmodule
`default_nettype wire

// [src/tdb_pkg.sv]
/*
  Shared constants, register map and arithmetic helpers for the tone detector bank.
  Assumes a single clock domain; every user of this package imports it whole.
*/
`default_nettype none
package tdb_pkg;
  // data path and cell counts
  localparam int TDB_DW = 16;
  localparam int TDB_NUM_PRI = 16;
  localparam int TDB_NUM_SEC = 4;
  localparam int TDB_NUM_CELL = 20;
  localparam int TDB_NUM_COEF = 14;
  localparam int TDB_NUM_PORT = 4;
  // nominal sample rates; the strobes that carry them come from the sample path
  localparam int TDB_PRI_RATE_HZ = 7200;
  localparam int TDB_SEC_SLOW_HZ = 4800;
  localparam int TDB_SEC_FAST_HZ = 9600;
  // register byte offsets on the bus
  localparam logic [7:0] TDB_OFF_CTRL = 8'h00;
  localparam logic [7:0] TDB_OFF_CMD = 8'h04;
  localparam logic [7:0] TDB_OFF_CMD_DATA = 8'h08;
  localparam logic [7:0] TDB_OFF_RESULT = 8'h0C;
  localparam logic [7:0] TDB_OFF_DETECT = 8'h10;
  localparam logic [7:0] TDB_OFF_STATUS = 8'h14;
  // control register bits and reset value
  localparam int TDB_CTRL_TONE = 0;
  localparam int TDB_CTRL_KEEP_PRI = 1;
  localparam int TDB_CTRL_KEEP_SEC = 2;
  localparam int TDB_CTRL_FAST = 3;
  localparam int TDB_CTRL_MON = 4;
  localparam logic [4:0] TDB_CTRL_RST = 5'h00;
  // command opcodes, field [11:8] of the command register
  localparam logic [3:0] TDB_OP_READ_COEFFICIENT = 4'h1;
  localparam logic [3:0] TDB_OP_READ_WIRING = 4'h2;
  localparam logic [3:0] TDB_OP_WRITE_COEFFICIENT = 4'h3;
  localparam logic [3:0] TDB_OP_WRITE_WIRING = 4'h4;
  localparam logic [3:0] TDB_OP_ZERO_CELL = 4'h5;
  // coefficient slots inside a cell: 0..11 filter, then smoothing, then level
  localparam logic [3:0] TDB_IDX_SMOOTH = 4'hC;
  localparam logic [3:0] TDB_IDX_LEVEL = 4'hD;
  // wiring port slots
  localparam int TDB_PORT_FILT = 0;
  localparam int TDB_PORT_POW = 1;
  localparam int TDB_PORT_POS = 2;
  localparam int TDB_PORT_NEG = 3;
  // wiring node codes
  localparam logic [7:0] TDB_NODE_RX1 = 8'h01;
  localparam logic [7:0] TDB_NODE_RX2 = 8'h02;
  localparam logic [7:0] TDB_NODE_RX4 = 8'h03;
  localparam logic [3:0] TDB_NODE_FILT = 4'h1;
  localparam logic [3:0] TDB_NODE_POW = 4'h2;
  localparam logic [3:0] TDB_NODE_LEVEL = 4'h3;
  localparam logic [7:0] TDB_SEL_LAST = 8'h13;
  // Q15 limits
  localparam logic signed [35:0] TDB_Q15_MAX = 36'sh000007FFF;
  localparam logic signed [35:0] TDB_Q15_MIN = -36'sh000008000;
  localparam logic signed [15:0] TDB_SAT_HI = 16'sh7FFF;
  localparam logic signed [15:0] TDB_SAT_LO = 16'sh8000;

  // clamp a wide intermediate into Q15 instead of letting it wrap
  function automatic logic signed [15:0] tdb_sat16(input logic signed [35:0] v);
    if (v > TDB_Q15_MAX) return TDB_SAT_HI;
    else if (v < TDB_Q15_MIN) return TDB_SAT_LO;
    else return v[15:0];
  endfunction

  // byte-lane merge for partial bus writes
  function automatic logic [31:0] tdb_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[8*b +: 8] = new_v[8*b +: 8];
    end
    return r;
  endfunction
endpackage
`default_nettype wire

// [src/tdb_top.sv]
/*
  Tone detector bank: sixteen primary and four secondary cells, node routing,
  comparators, detection words and an Avalon-MM register slave with waitrequest.
  Assumes sample, secondary-base and baud strobes are one-cycle pulses from logic
  on clk, with the receive sample valid while its strobe is high.
*/
`default_nettype none
module tdb_top
  import tdb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register bus
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // sample path
  input wire logic signed [15:0] receive_sample,
  input wire logic sample_stb,
  input wire logic sec_base_stb,
  input wire logic baud_stb,
  // detection results
  output logic [7:0] detect_word_low,
  output logic [7:0] detect_word_high,
  output logic [3:0] detect_word_sec,
  output logic mon_valid,
  output logic [19:0] mon_word
);
  localparam int NC = TDB_NUM_CELL;

  // bus and control state
  logic wait_r, init_r, tone_prev_r, half_r, err_r;
  logic [31:0] rdata_r, cmd_data_r, result_r;
  logic [4:0] ctrl_r;
  logic [7:0] det_low_r, det_high_r;
  logic [3:0] det_sec_r;
  logic mon_valid_r;
  logic [19:0] mon_word_r;
  logic [7:0] wire_r [NC][TDB_NUM_PORT];

  // cell interconnect
  logic [16*TDB_NUM_PRI-1:0] filt_flat, pow_flat, lvl_flat;
  logic signed [15:0] filt_o [NC];
  logic signed [15:0] pow_o [NC];
  logic signed [15:0] lvl_o [NC];
  logic [15:0] rd_o [NC];
  logic [NC-1:0] cmp_bits;

  // node selection: constant zero, scaled receive, or a primary cell's output
  function automatic logic signed [15:0] node_val(input logic [7:0] code,
      input logic signed [15:0] rx, input logic [16*TDB_NUM_PRI-1:0] f,
      input logic [16*TDB_NUM_PRI-1:0] p, input logic [16*TDB_NUM_PRI-1:0] l);
    logic signed [15:0] v;
    v = 16'sh0000;
    case (code[7:4])
      4'h0: begin
        if (code == TDB_NODE_RX1) v = rx;
        else if (code == TDB_NODE_RX2) v = tdb_sat16(36'(rx) * 2);
        else if (code == TDB_NODE_RX4) v = tdb_sat16(36'(rx) * 4);
      end
      TDB_NODE_FILT: v = f[16*code[3:0] +: 16];
      TDB_NODE_POW: v = p[16*code[3:0] +: 16];
      TDB_NODE_LEVEL: v = l[16*code[3:0] +: 16];
      default: v = 16'sh0000; // reserved codes read as ground
    endcase
    return v;
  endfunction

  // bus decode; a request completes on the edge where waitrequest is low
  logic bus_req, bus_done, wr_done, cmd_go, cell_ok;
  logic [3:0] cmd_op, cmd_idx;
  logic [7:0] cmd_cell;
  logic [4:0] cmd_ci;
  logic tone_en, keep_pri, keep_sec, fast, mon_en, sec_stb, pri_stb;
  logic [31:0] rd_mux, ctrl_merged, data_merged;
  logic [15:0] rd_sel;
  logic cmd_bad;
  assign bus_req = avs_read || avs_write;
  assign bus_done = bus_req && !wait_r;
  assign wr_done = avs_write && !wait_r;
  assign cmd_go = wr_done && avs_address == TDB_OFF_CMD;
  assign cmd_cell = avs_writedata[7:0];
  assign cmd_op = avs_writedata[11:8];
  assign cmd_idx = avs_writedata[15:12];
  assign cmd_ci = cmd_cell[4:0];
  assign cell_ok = cmd_cell <= TDB_SEL_LAST;
  assign rd_sel = rd_o[cmd_ci];
  assign cmd_bad = !cell_ok || (cmd_op == TDB_OP_READ_COEFFICIENT && cmd_idx > TDB_IDX_LEVEL)
                   || (cmd_op == TDB_OP_WRITE_COEFFICIENT && cmd_idx > TDB_IDX_LEVEL)
                   || cmd_op == 4'h0 || cmd_op > TDB_OP_ZERO_CELL;
  assign ctrl_merged = tdb_merge({27'h0000000, ctrl_r}, avs_writedata, avs_byteenable);
  assign data_merged = tdb_merge(cmd_data_r, avs_writedata, avs_byteenable);

  // control fields
  assign tone_en = ctrl_r[TDB_CTRL_TONE];
  assign keep_pri = ctrl_r[TDB_CTRL_KEEP_PRI];
  assign keep_sec = ctrl_r[TDB_CTRL_KEEP_SEC];
  assign fast = ctrl_r[TDB_CTRL_FAST];
  assign mon_en = ctrl_r[TDB_CTRL_MON];

  // strobes: primaries at the primary rate, secondaries at the base or half of it
  assign pri_stb = tone_en && sample_stb;
  assign sec_stb = tone_en && sec_base_stb && (fast || half_r);

  // read mux; unmapped offsets read as zero
  always_comb begin
    case (avs_address)
      TDB_OFF_CTRL: rd_mux = {27'h0000000, ctrl_r};
      TDB_OFF_CMD_DATA: rd_mux = cmd_data_r;
      TDB_OFF_RESULT: rd_mux = result_r;
      TDB_OFF_DETECT: rd_mux = {12'h000, det_sec_r, det_high_r, det_low_r};
      TDB_OFF_STATUS: rd_mux = {29'h00000000, fast, err_r, tone_en};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // flatten the primary outputs so the node function can index them
  genvar gi;
  generate
    for (gi = 0; gi < TDB_NUM_PRI; gi++) begin : g_flat
      assign filt_flat[16*gi +: 16] = filt_o[gi];
      assign pow_flat[16*gi +: 16] = pow_o[gi];
      assign lvl_flat[16*gi +: 16] = lvl_o[gi];
    end
  endgenerate

  // the twenty cells with their routing and comparators
  generate
    for (gi = 0; gi < NC; gi++) begin : g_cell
      localparam bit IS_SEC = (gi >= TDB_NUM_PRI);
      logic signed [15:0] f_in, p_in, pos_v, neg_v;
      logic signed [16:0] diff;
      logic hit, wr_en, zero_en;
      assign hit = cmd_go && cell_ok && !cmd_bad && cmd_ci == 5'(gi);
      assign wr_en = hit && cmd_op == TDB_OP_WRITE_COEFFICIENT;
      assign zero_en = hit && cmd_op == TDB_OP_ZERO_CELL;
      assign f_in = node_val(wire_r[gi][TDB_PORT_FILT], receive_sample,
                             filt_flat, pow_flat, lvl_flat);
      assign p_in = node_val(wire_r[gi][TDB_PORT_POW], receive_sample,
                             filt_flat, pow_flat, lvl_flat);
      // a secondary's negative input may be a level (absolute) or receive (relative)
      assign pos_v = node_val(wire_r[gi][TDB_PORT_POS], receive_sample,
                              filt_flat, pow_flat, lvl_flat);
      assign neg_v = node_val(wire_r[gi][TDB_PORT_NEG], receive_sample,
                              filt_flat, pow_flat, lvl_flat);
      assign diff = 17'(pos_v) - 17'(neg_v);
      assign cmp_bits[gi] = diff > 17'sh00000;
      tdb_cell u_cell (
        .clk(clk),
        .sys_rst(sys_rst),
        .init_state(init_r),
        .init_coef(init_r && (IS_SEC ? !keep_sec : !keep_pri)),
        .samp_stb(IS_SEC ? sec_stb : pri_stb),
        .filt_in(f_in),
        .pow_in(p_in),
        .wr_en(wr_en),
        .zero_en(zero_en),
        .wr_idx(cmd_idx),
        .wr_data(cmd_data_r[15:0]),
        .rd_idx(cmd_idx),
        .rd_data(rd_o[gi]),
        .filt_out(filt_o[gi]),
        .pow_out(pow_o[gi]),
        .level_out(lvl_o[gi])
      );
      // wiring store; cleared with the coefficients of the same group
      always_ff @(posedge clk) begin
        if (sys_rst || zero_en || (init_r && (IS_SEC ? !keep_sec : !keep_pri))) begin
          for (int p = 0; p < TDB_NUM_PORT; p++) wire_r[gi][p] <= 8'h00;
        end else if (hit && cmd_op == TDB_OP_WRITE_WIRING) begin
          if (cmd_idx[0]) begin
            wire_r[gi][TDB_PORT_NEG] <= cmd_data_r[15:8];
            wire_r[gi][TDB_PORT_POS] <= cmd_data_r[7:0];
          end else begin
            wire_r[gi][TDB_PORT_POW] <= cmd_data_r[15:8];
            wire_r[gi][TDB_PORT_FILT] <= cmd_data_r[7:0];
          end
        end
      end
    end
  endgenerate

  // bus handshake: one wait cycle per request, then a single ready edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h00000000;
    end else begin
      wait_r <= !(bus_req && wait_r);
      if (avs_read && wait_r) rdata_r <= rd_mux;
    end
  end

  // software-written registers and command results
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_r <= TDB_CTRL_RST;
      cmd_data_r <= 32'h00000000;
      result_r <= 32'h00000000;
      err_r <= 1'b0;
    end else begin
      if (wr_done && avs_address == TDB_OFF_CTRL) ctrl_r <= ctrl_merged[4:0];
      if (wr_done && avs_address == TDB_OFF_CMD_DATA) cmd_data_r <= data_merged;
      if (cmd_go) err_r <= cmd_bad; // last command's verdict
      if (cmd_go && !cmd_bad && cmd_op == TDB_OP_READ_COEFFICIENT)
        result_r <= {16'h0000, rd_sel};
      else if (cmd_go && !cmd_bad && cmd_op == TDB_OP_READ_WIRING)
        result_r <= cmd_idx[0] ? {16'h0000, wire_r[cmd_ci][TDB_PORT_NEG],
                                  wire_r[cmd_ci][TDB_PORT_POS]}
                               : {16'h0000, wire_r[cmd_ci][TDB_PORT_POW],
                                  wire_r[cmd_ci][TDB_PORT_FILT]};
    end
  end

  // tone-mode entry detect and secondary rate divider
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tone_prev_r <= 1'b0;
      init_r <= 1'b0;
      half_r <= 1'b0;
    end else begin
      tone_prev_r <= tone_en;
      init_r <= tone_en && !tone_prev_r;
      if (init_r) half_r <= 1'b0;
      else if (tone_en && sec_base_stb) half_r <= !half_r;
    end
  end

  // comparators sampled once per baud into the detection words
  always_ff @(posedge clk) begin
    if (sys_rst || init_r) begin
      det_low_r <= 8'h00;
      det_high_r <= 8'h00;
      det_sec_r <= 4'h0;
      mon_valid_r <= 1'b0;
      mon_word_r <= 20'h00000;
    end else begin
      mon_valid_r <= 1'b0;
      if (tone_en && baud_stb) begin
        det_low_r <= cmp_bits[7:0];
        det_high_r <= cmp_bits[15:8];
        det_sec_r <= cmp_bits[19:16];
        if (mon_en) begin
          mon_valid_r <= 1'b1;
          mon_word_r <= cmp_bits;
        end
      end
    end
  end

  // outputs straight from flip-flops
  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;
  assign detect_word_low = det_low_r;
  assign detect_word_high = det_high_r;
  assign detect_word_sec = det_sec_r;
  assign mon_valid = mon_valid_r;
  assign mon_word = mon_word_r;

  bus_answer_a: assert property (@(posedge clk) disable iff (sys_rst)
    bus_req && wait_r |=> !wait_r ##1 wait_r)
    else $error("bus answer not one cycle after request");
  detect_low_a: assert property (@(posedge clk) disable iff (sys_rst)
    tone_en && baud_stb && !init_r |=> det_low_r == $past(cmp_bits[7:0]))
    else $error("low detection word not loaded at baud");
  detect_high_a: assert property (@(posedge clk) disable iff (sys_rst)
    tone_en && baud_stb && !init_r |=> det_high_r == $past(cmp_bits[15:8]))
    else $error("high detection word not loaded at baud");
  detect_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !baud_stb && !init_r |=> $stable(det_low_r) && $stable(det_high_r))
    else $error("detection word changed between bauds");
  monitor_report_a: assert property (@(posedge clk) disable iff (sys_rst)
    tone_en && mon_en && baud_stb && !init_r |=> mon_valid_r && mon_word_r[15:0] ==
    {det_high_r, det_low_r})
    else $error("baud report missing or mismatched");
  slow_rate_a: assert property (@(posedge clk) disable iff (sys_rst)
    sec_stb && !fast |-> !$past(sec_stb, 1) && sec_base_stb)
    else $error("secondary strobe faster than half base in slow mode");
  entry_init_a: assert property (@(posedge clk) disable iff (sys_rst)
    tone_en && !tone_prev_r |=> init_r ##1 !init_r)
    else $error("tone-mode entry did not clear the cells once");
  secondary_sel_a: assert property (@(posedge clk) disable iff (sys_rst)
    cmd_go && cmd_cell > TDB_SEL_LAST |=> err_r)
    else $error("selector beyond secondary range accepted");
endmodule
`default_nettype wire

// [tb/tdb_sample_src.sv]
/*
  Receive sample source standing in for the analog front end.
  Assumes the clock of the detector bank; strobes are one-cycle pulses.
*/
`default_nettype none
module tdb_sample_src (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // sample path
  output logic sample_stb,
  output logic sec_base_stb,
  output logic signed [15:0] receive_sample
);
  timeunit 1ns;
  timeprecision 1ps;
  // small level keeps every filter node well under half scale
  localparam logic signed [15:0] SMP = 16'sh0800;
  logic [4:0] cnt_r;
  // sample strobe every 20 cycles, secondary base twice as often
  always_ff @(posedge clk) begin
    if (sys_rst) cnt_r <= 5'h00;
    else cnt_r <= (cnt_r == 5'h13) ? 5'h00 : cnt_r + 5'h01;
  end
  assign sample_stb = (cnt_r == 5'h00);
  assign sec_base_stb = (cnt_r == 5'h05) || (cnt_r == 5'h0F);
  // outside a strobe the value is not held, so a stale read shows up
  assign receive_sample = (sample_stb || sec_base_stb) ? SMP : ~SMP;
endmodule
`default_nettype wire

// [tb/tdb_top_tb.sv]
/*
  Self-checking bench for the tone detector bank: register rows, then commands,
  detection words, monitoring and tone-mode entry. Assumes the sample source model.
*/
`default_nettype none
module tdb_top_tb;
  import tdb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} tdb_row_s;
  logic clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, baud_stb = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [3:0] avs_byteenable = 4'hF, detect_word_sec;
  logic avs_waitrequest, sample_stb, sec_base_stb, mon_valid;
  logic signed [15:0] receive_sample;
  logic [7:0] detect_word_low, detect_word_high;
  logic [19:0] mon_word;
  int n_mismatch = 0, total_checks = 0;
  // section gains of a pass-through filter: both gains and both leading numerator taps
  logic [3:0] gain_idx [4] = '{4'h0, 4'h5, 4'h6, 4'hB};
  tdb_row_s rows [4] = '{'{TDB_OFF_CTRL, 32'h08, 32'h08}, '{8'h20, 32'h55, 32'h0},
    '{TDB_OFF_CMD_DATA, 32'h1234, 32'h1234}, '{TDB_OFF_DETECT, 32'hFF, 32'h0}};
  tdb_sample_src src (.clk, .sys_rst, .sample_stb, .sec_base_stb, .receive_sample);
  tdb_top uut (.clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .receive_sample, .sample_stb,
    .sec_base_stb, .baud_stb, .detect_word_low, .detect_word_high, .detect_word_sec,
    .mon_valid, .mon_word);
  // 100 MHz clock
  always #5 clk = ~clk;
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one bus access: hold everything until waitrequest is sampled low
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= we;
    avs_read <= !we;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50) begin
      n_mismatch++;
      complete_run();
    end
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  task automatic cmd(input logic [7:0] s, input logic [3:0] op, idx, input logic [15:0] d);
    bus(1'b1, TDB_OFF_CMD_DATA, {16'h0, d});
    bus(1'b1, TDB_OFF_CMD, {16'h0, idx, op, s});
  endtask
  // baud pulse, outputs looked at one cycle later, monitor pulse then gone
  task automatic baud(input logic [19:0] e, input logic mv);
    @(posedge clk);
    baud_stb <= 1'b1;
    @(posedge clk);
    baud_stb <= 1'b0;
    #1;
    chk("detect", e, {detect_word_sec, detect_word_high, detect_word_low});
    chk("mon_valid", mv, mon_valid);
    if (mv) chk("mon_word", e, mon_word);
    @(posedge clk);
    #1;
    chk("mon_fall", 1'b0, mon_valid);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    chk("rst_detect", 20'h0, {detect_word_sec, detect_word_high, detect_word_low});
    rd("ctrl_rst", TDB_OFF_CTRL, 32'h0);
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d);
      rd("row", rows[i].a, rows[i].e);
    end
    rd("status_fast", TDB_OFF_STATUS, 32'h4);
    bus(1'b1, TDB_OFF_CTRL, 32'h0);
    // levels of opposite sign on cells 0, 1 and 8; secondary compares two of them
    cmd(8'h00, TDB_OP_WRITE_COEFFICIENT, TDB_IDX_LEVEL, 16'h2000);
    cmd(8'h01, TDB_OP_WRITE_COEFFICIENT, TDB_IDX_LEVEL, 16'hE000);
    cmd(8'h08, TDB_OP_WRITE_COEFFICIENT, TDB_IDX_LEVEL, 16'h0100);
    cmd(8'h00, TDB_OP_WRITE_WIRING, 4'h1, 16'h0030);
    cmd(8'h01, TDB_OP_WRITE_WIRING, 4'h1, 16'h0031);
    cmd(8'h08, TDB_OP_WRITE_WIRING, 4'h1, 16'h0038);
    cmd(8'h10, TDB_OP_WRITE_WIRING, 4'h1, 16'h3130);
    // cell 2 integrates the receive signal, cell 3 filters it; both compare against ground
    cmd(8'h02, TDB_OP_WRITE_COEFFICIENT, TDB_IDX_SMOOTH, 16'h4000);
    cmd(8'h02, TDB_OP_WRITE_WIRING, 4'h0, 16'h0100);
    cmd(8'h02, TDB_OP_WRITE_WIRING, 4'h1, 16'h0022);
    foreach (gain_idx[i]) cmd(8'h03, TDB_OP_WRITE_COEFFICIENT, gain_idx[i], 16'h7FFF);
    cmd(8'h03, TDB_OP_WRITE_WIRING, 4'h0, 16'h0001);
    cmd(8'h03, TDB_OP_WRITE_WIRING, 4'h1, 16'h0013);
    cmd(8'h00, TDB_OP_READ_COEFFICIENT, TDB_IDX_LEVEL, 16'h0);
    rd("coef", TDB_OFF_RESULT, 32'h2000);
    cmd(8'h14, TDB_OP_ZERO_CELL, 4'h0, 16'h0);
    rd("bad_cell", TDB_OFF_STATUS, 32'h2);
    cmd(8'h10, TDB_OP_READ_WIRING, 4'h1, 16'h0);
    rd("wiring", TDB_OFF_RESULT, 32'h3130);
    cmd(8'h00, 4'h7, 4'h0, 16'h0);
    rd("bad_op", TDB_OFF_STATUS, 32'h2);
    // entry with both keep bits and monitoring; strobes run meanwhile
    bus(1'b1, TDB_OFF_CTRL, 32'h17);
    repeat (60) @(posedge clk);
    baud({4'h1, 8'h01, 8'h0D}, 1'b1);
    rd("detect_reg", TDB_OFF_DETECT, 32'h1010D);
    cmd(8'h08, TDB_OP_ZERO_CELL, 4'h0, 16'h0);
    baud({4'h1, 8'h00, 8'h0D}, 1'b1);
    // tone mode off: the baud strobe is ignored and the words hold their last value
    bus(1'b1, TDB_OFF_CTRL, 32'h0);
    baud({4'h1, 8'h00, 8'h0D}, 1'b0);
    // re-entry without keep bits clears coefficients and wiring
    bus(1'b1, TDB_OFF_CTRL, 32'h1);
    repeat (40) @(posedge clk);
    baud(20'h0, 1'b0);
    cmd(8'h00, TDB_OP_READ_COEFFICIENT, TDB_IDX_LEVEL, 16'h0);
    rd("coef_init", TDB_OFF_RESULT, 32'h0);
    // mid-run reset; the first access is raised on the edge right after release
    cmd(8'h05, TDB_OP_WRITE_COEFFICIENT, TDB_IDX_LEVEL, 16'h1234);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd("rst_ctrl", TDB_OFF_CTRL, 32'h0);
    cmd(8'h05, TDB_OP_READ_COEFFICIENT, TDB_IDX_LEVEL, 16'h0);
    rd("rst_coef", TDB_OFF_RESULT, 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire
